// ==== logic/olrc_top.sv ====
// output limit and reset configuration: register file, error checking,
// off-state limit selection, reset and device-clear handling.
// assumes a flash controller that loads and stores olrc_vars_t.
// Functional notes
// - config writes change working copies only
// - at power-up working copies load from the flash image
// - window and error settings persist only by shutdown; others by interface persist; code persists sysopt from staged_sys, copied from work only by C_STAGE
// - measure output, check tolerance, set questionable bits
// - factory default window is 32 measurement steps
// - device errors: window, on-limit, hard limit
// - enabled errors force output off at once; code forces off only errors whose E_WIN_OFF, E_ONL_OFF or E_HARD_OFF is set
// - error settings last until power cycle unless persisted
// - off-state limits minimum or maximum (110% rated)
// - selector 0: both limits zero when off
// - selector 1: voltage limit max; 2: current limit max
// - bits 2, 3 take programmed off-limit voltage, current
// - maximum bit overrides matching programmed-value bit
// - factory restore sets selector to 0
// - factory restore: option bits cleared, defaults, flash erase
// - lf option set: empty read returns line feed
// - lf option clear: each string answered by one line feed
// - status-only device clear touches status, not output
// - device clear as reset acts like reset
// - reset with output-off option: zero setpoints, output off
// - reset with output-on option: output on at zero setpoints
// - message ends on LF, CR or both; second of pair ignored
//
// Design decisions made here: the register addresses and the AXI4-Lite register port.
`timescale 1ns/1ns
`default_nettype none
module olrc_top
    import olrc_pkg::*;
#(
    parameter logic [CW-1:0] V_MAX = 16'hffff,
    parameter logic [CW-1:0] I_MAX = 16'hffff
) (
    input wire logic aclk,
    input wire logic aresetn,
    // axi4-lite slave
    input wire logic [olrc_pkg::AW-1:0] s_awaddr,
    input wire logic s_awvalid,
    output logic s_awready,
    input wire logic [olrc_pkg::DW-1:0] s_wdata,
    input wire logic [3:0] s_wstrb,
    input wire logic s_wvalid,
    output logic s_wready,
    output logic [1:0] s_bresp,
    output logic s_bvalid,
    input wire logic s_bready,
    input wire logic [olrc_pkg::AW-1:0] s_araddr,
    input wire logic s_arvalid,
    output logic s_arready,
    output logic [olrc_pkg::DW-1:0] s_rdata,
    output logic [1:0] s_rresp,
    output logic s_rvalid,
    input wire logic s_rready,
    // flash image side
    input wire olrc_pkg::olrc_vars_t flash_vars,
    input wire logic flash_valid,
    output olrc_pkg::olrc_vars_t persist_vars,
    output logic persist_shut,
    output logic persist_if,
    output logic factory_erase,
    // measurement and bus port events
    input wire logic [olrc_pkg::CW-1:0] meas_value,
    input wire logic meas_valid,
    input wire logic [olrc_pkg::CW-1:0] hard_limit,
    input wire logic [7:0] rx_char,
    input wire logic rx_valid,
    input wire logic out_buf_empty,
    // outputs toward the supply
    output olrc_pkg::olrc_lim_t lim_dac,
    output olrc_pkg::olrc_lim_t prog_dac,
    output logic output_on,
    output logic volt_mode,
    output logic [2:0] quest_status,
    output logic [2:0] dev_error,
    output logic [7:0] tx_char,
    output logic tx_valid,
    output logic status_clear
);
    import olrc_pkg::*;

    initial begin
        if (V_MAX == '0 || I_MAX == '0) begin
            $error("olrc_top: zero limit");
        end
    end

    // ------------
    // working copies and state
    // ------------
    olrc_vars_t work;
    logic [2:0] staged_sys;
    logic loaded;
    logic [CW-1:0] set_v, set_i;
    logic [AW-1:0] awaddr;
    logic aw_held, w_held;
    logic [DW-1:0] wdata;
    logic [3:0] cmd;
    logic cmd_go;
    logic last_cr, last_lf;
    logic [2:0] err_now;
    logic force_off;

    // ------------
    // axi4-lite write path
    // ------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_awready <= 1'b1;
            s_wready <= 1'b1;
            aw_held <= 1'b0;
            w_held <= 1'b0;
            awaddr <= '0;
            wdata <= '0;
            s_bvalid <= 1'b0;
            s_bresp <= RESP_OKAY;
        end else begin
            if (s_awvalid && s_awready) begin
                awaddr <= s_awaddr;
                aw_held <= 1'b1;
                s_awready <= 1'b0;
            end
            if (s_wvalid && s_wready) begin
                wdata <= s_wdata;
                w_held <= 1'b1;
                s_wready <= 1'b0;
            end
            if (aw_held && w_held && !s_bvalid) begin
                s_bvalid <= 1'b1;
                s_bresp <= (awaddr > A_SETPT || awaddr[1:0] != 2'b00)
                    ? RESP_SLVERR : RESP_OKAY;
            end
            if (s_bvalid && s_bready) begin
                s_bvalid <= 1'b0;
                aw_held <= 1'b0;
                w_held <= 1'b0;
                s_awready <= 1'b1;
                s_wready <= 1'b1;
            end
        end
    end

    logic s_wstrb_seen;
    wire wr_fire = aw_held && w_held && !s_bvalid;
    wire wr_low = wr_fire && s_wstrb_seen;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_wstrb_seen <= 1'b0;
        end else if (s_wvalid && s_wready) begin
            s_wstrb_seen <= s_wstrb[0] | s_wstrb[1];
        end
    end

    // ------------
    // configuration registers (working copies only)
    // ------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            work <= '0;
            work.window <= WINDOW_DEF;
            staged_sys <= '0;
            loaded <= 1'b0;
        end else if (!loaded) begin
            if (flash_valid) begin
                work <= flash_vars;
                staged_sys <= flash_vars.sysopt;
                loaded <= 1'b1;
            end
        end else if (cmd_go && cmd == C_FACTORY) begin
            work <= '0;
            work.window <= WINDOW_DEF;
            staged_sys <= '0;
        end else if (wr_low) begin
            unique case (awaddr)
                A_ERRCFG: work.err_cfg <= wdata[7:0];
                A_WINDOW: work.window <= wdata[CW-1:0];
                A_OFFSEL: work.sel <= wdata[3:0];
                A_OFFLIM: begin
                    work.off_v <= wdata[CW-1:0];
                    work.off_i <= wdata[DW-1:CW];
                end
                A_ONLIM: work.on_i <= wdata[CW-1:0];
                A_SYSOPT: work.sysopt <= wdata[2:0];
                default: ;
            endcase
        end else if (cmd_go && cmd == C_STAGE) begin
            staged_sys <= work.sysopt;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cmd <= C_NONE;
            cmd_go <= 1'b0;
        end else begin
            cmd_go <= wr_low && awaddr == A_CMD;
            cmd <= wdata[3:0];
        end
    end

    // ------------
    // persist and factory restore strobes
    // ------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            persist_vars <= '0;
            persist_shut <= 1'b0;
            persist_if <= 1'b0;
            factory_erase <= 1'b0;
        end else begin
            persist_shut <= cmd_go && cmd == C_PERSIST_SHUT;
            persist_if <= cmd_go && cmd == C_PERSIST_IF;
            factory_erase <= cmd_go && cmd == C_FACTORY;
            if (cmd_go && cmd == C_PERSIST_SHUT) begin
                persist_vars.window <= work.window;
                persist_vars.err_cfg <= work.err_cfg;
            end
            if (cmd_go && cmd == C_PERSIST_IF) begin
                persist_vars.sel <= work.sel;
                persist_vars.off_v <= work.off_v;
                persist_vars.off_i <= work.off_i;
                persist_vars.on_i <= work.on_i;
                persist_vars.sysopt <= staged_sys;
            end
            if (cmd_go && cmd == C_FACTORY) begin
                persist_vars <= '0;
                persist_vars.window <= WINDOW_DEF;
            end
        end
    end

    // ------------
    // tolerance check and error detection
    // ------------
    wire [CW:0] diff_up = {1'b0, meas_value} - {1'b0, set_v};
    wire [CW:0] diff_dn = {1'b0, set_v} - {1'b0, meas_value};
    wire [CW-1:0] dev = diff_up[CW] ? diff_dn[CW-1:0] : diff_up[CW-1:0];
    wire win_bad = output_on && dev > work.window;
    wire onl_bad = output_on && work.on_i != '0 && set_i >= work.on_i;
    wire hard_bad = output_on && meas_value > hard_limit;

    always_comb begin
        err_now = {hard_bad, onl_bad, win_bad};
        force_off = meas_valid && ((win_bad && work.err_cfg[E_WIN_OFF])
            || (onl_bad && work.err_cfg[E_ONL_OFF])
            || (hard_bad && work.err_cfg[E_HARD_OFF]));
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            quest_status <= '0;
            dev_error <= '0;
        end else if (meas_valid) begin
            quest_status <= err_now;
            dev_error <= err_now & {work.err_cfg[E_HARD_ERR],
                work.err_cfg[E_ONL_ERR], work.err_cfg[E_WIN_ERR]};
        end
    end

    // ------------
    // output state, reset and device clear
    // ------------
    wire do_rst = cmd_go && (cmd == C_RST
        || (cmd == C_DCL && work.sysopt[S_DC]));

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            output_on <= 1'b0;
            volt_mode <= 1'b1;
            set_v <= '0;
            set_i <= '0;
            status_clear <= 1'b0;
        end else begin
            status_clear <= cmd_go && cmd == C_DCL;
            if (force_off) begin
                output_on <= 1'b0;
            end else if (do_rst) begin
                set_v <= '0;
                set_i <= '0;
                volt_mode <= 1'b1;
                output_on <= work.sysopt[S_RO];
            end else if (cmd_go && cmd == C_OUTP_ON) begin
                output_on <= 1'b1;
            end else if (cmd_go && cmd == C_OUTP_OFF) begin
                output_on <= 1'b0;
            end else if (wr_low && awaddr == A_SETPT) begin
                set_v <= wdata[CW-1:0];
                set_i <= wdata[DW-1:CW];
            end
        end
    end

    // ------------
    // converter drive with off-state limits
    // ------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            lim_dac <= '0;
            prog_dac <= '0;
        end else if (output_on && !force_off) begin
            prog_dac.v <= set_v;
            prog_dac.i <= set_i;
            lim_dac.v <= V_MAX;
            lim_dac.i <= (work.on_i != '0) ? work.on_i : I_MAX;
        end else begin
            prog_dac <= '0;
            lim_dac.v <= work.sel[L_VMAX] ? V_MAX
                : work.sel[L_VPROG] ? work.off_v : '0;
            lim_dac.i <= work.sel[L_IMAX] ? I_MAX
                : work.sel[L_IPROG] ? work.off_i : '0;
        end
    end

    // ------------------------------------------------------------
    // terminator handling and line-feed answers
    // ------------------------------------------------------------
    wire is_term = rx_char == CH_LF || rx_char == CH_CR;
    wire second = (rx_char == CH_LF && last_cr)
        || (rx_char == CH_CR && last_lf);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            last_cr <= 1'b0;
            last_lf <= 1'b0;
            tx_char <= '0;
            tx_valid <= 1'b0;
        end else begin
            tx_valid <= 1'b0;
            tx_char <= CH_LF;
            if (rx_valid) begin
                last_cr <= rx_char == CH_CR && !second;
                last_lf <= rx_char == CH_LF && !second;
                if (is_term && !second && !work.sysopt[S_LF]) begin
                    tx_valid <= 1'b1;
                end
            end else if (cmd_go && cmd == C_READ && out_buf_empty
                    && work.sysopt[S_LF]) begin
                tx_valid <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // axi4-lite read path
    // ------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_arready <= 1'b1;
            s_rvalid <= 1'b0;
            s_rdata <= '0;
            s_rresp <= RESP_OKAY;
        end else if (s_rvalid) begin
            if (s_rready) begin
                s_rvalid <= 1'b0;
                s_arready <= 1'b1;
            end
        end else if (s_arvalid) begin
            s_arready <= 1'b0;
            s_rvalid <= 1'b1;
            s_rresp <= RESP_OKAY;
            unique case (s_araddr)
                A_CMD: s_rdata <= '0;
                A_ERRCFG: s_rdata <= {24'h0, work.err_cfg};
                A_WINDOW: s_rdata <= {16'h0, work.window};
                A_OFFSEL: s_rdata <= {28'h0, work.sel};
                A_OFFLIM: s_rdata <= {work.off_i, work.off_v};
                A_ONLIM: s_rdata <= {16'h0, work.on_i};
                A_SYSOPT: s_rdata <= {29'h0, work.sysopt};
                A_SETPT: s_rdata <= {set_i, set_v};
                A_STATUS: s_rdata <= {24'h0, dev_error, quest_status,
                    volt_mode, output_on};
                A_MEAS: s_rdata <= {16'h0, meas_value};
                A_LIMOUT: s_rdata <= {lim_dac.i, lim_dac.v};
                default: begin
                    s_rdata <= '0;
                    s_rresp <= RESP_SLVERR;
                end
            endcase
        end
    end
endmodule
`default_nettype wire

// ==== include/olrc_pkg.sv ====
// package for olrc_top
// assumes an axi4-lite master on aclk and a flash loader/writer beside it
package olrc_pkg;
    localparam int DW = 32;
    localparam int AW = 8;
    localparam int CW = 16;
    // register byte addresses
    localparam logic [AW-1:0] A_CMD = 8'h00;
    localparam logic [AW-1:0] A_ERRCFG = 8'h04;
    localparam logic [AW-1:0] A_WINDOW = 8'h08;
    localparam logic [AW-1:0] A_OFFSEL = 8'h0c;
    localparam logic [AW-1:0] A_OFFLIM = 8'h10;
    localparam logic [AW-1:0] A_ONLIM = 8'h14;
    localparam logic [AW-1:0] A_SYSOPT = 8'h18;
    localparam logic [AW-1:0] A_SETPT = 8'h1c;
    localparam logic [AW-1:0] A_STATUS = 8'h20;
    localparam logic [AW-1:0] A_MEAS = 8'h24;
    localparam logic [AW-1:0] A_LIMOUT = 8'h28;
    // command codes written to A_CMD
    localparam logic [3:0] C_NONE = 4'h0;
    localparam logic [3:0] C_RST = 4'h1;
    localparam logic [3:0] C_DCL = 4'h2;
    localparam logic [3:0] C_OUTP_ON = 4'h3;
    localparam logic [3:0] C_OUTP_OFF = 4'h4;
    localparam logic [3:0] C_PERSIST_SHUT = 4'h5;
    localparam logic [3:0] C_PERSIST_IF = 4'h6;
    localparam logic [3:0] C_FACTORY = 4'h7;
    localparam logic [3:0] C_STAGE = 4'h8;
    localparam logic [3:0] C_READ = 4'h9;
    // error config bits
    localparam int E_WIN_ERR = 0;
    localparam int E_ONL_ERR = 1;
    localparam int E_HARD_ERR = 2;
    localparam int E_WIN_OFF = 3;
    localparam int E_ONL_OFF = 4;
    localparam int E_HARD_OFF = 5;
    // system option bits
    localparam int S_LF = 0;
    localparam int S_DC = 1;
    localparam int S_RO = 2;
    // selector bits
    localparam int L_VMAX = 0;
    localparam int L_IMAX = 1;
    localparam int L_VPROG = 2;
    localparam int L_IPROG = 3;
    localparam logic [CW-1:0] WINDOW_DEF = 16'h0020;
    localparam logic [7:0] CH_LF = 8'h0a;
    localparam logic [7:0] CH_CR = 8'h0d;
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;
    // flash image of the settings
    typedef struct packed {
        logic [7:0] err_cfg;
        logic [CW-1:0] window;
        logic [3:0] sel;
        logic [CW-1:0] off_v;
        logic [CW-1:0] off_i;
        logic [CW-1:0] on_i;
        logic [2:0] sysopt;
    } olrc_vars_t;
    // limit converter channel pair
    typedef struct packed {
        logic [CW-1:0] v;
        logic [CW-1:0] i;
    } olrc_lim_t;
endpackage

// ==== sim/olrc_asserts.sv ====
// checker for olrc_top, on its ports
// assumes one aclk domain and aresetn synchronous, active low
`timescale 1ns/1ns
`default_nettype none
module olrc_asserts
    import olrc_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [olrc_pkg::CW-1:0] meas_value,
    input wire logic meas_valid,
    input wire logic [olrc_pkg::CW-1:0] hard_limit,
    input wire logic [7:0] rx_char,
    input wire logic rx_valid,
    input wire logic output_on,
    input wire logic [2:0] quest_status,
    input wire logic [2:0] dev_error,
    input wire logic [7:0] tx_char,
    input wire logic tx_valid,
    input wire logic persist_shut,
    input wire logic persist_if
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // ----------------------------------------------------------------
    // rule checks
    // ----------------------------------------------------------------
    a_tx_is_lf: assert property (tx_valid |-> tx_char == CH_LF)
        else $error("answer not a line feed");
    a_pair_ignored: assert property (
        (rx_valid && rx_char == CH_CR) ##1
        (rx_valid && rx_char == CH_LF) |=> !tx_valid)
        else $error("pair answered twice");
    a_tx_cause: assert property (
        tx_valid && $past(rx_valid) |->
        $past(rx_char) == CH_LF || $past(rx_char) == CH_CR)
        else $error("answer without terminator");
    a_plain_char: assert property (
        rx_valid && rx_char != CH_LF && rx_char != CH_CR |=> !tx_valid)
        else $error("plain char answered");
    a_dev_gated: assert property ((dev_error & ~quest_status) == 3'h0)
        else $error("error without status");
    a_quest_cause: assert property (
        quest_status != 3'h0 && quest_status != $past(quest_status)
        |-> $past(meas_valid))
        else $error("status without measurement");
    a_hard_flag: assert property (
        $past(meas_valid) && $past(output_on)
        && $past(meas_value) != $past(hard_limit) |->
        quest_status[2] == ($past(meas_value) > $past(hard_limit)))
        else $error("hard limit flag wrong");
    a_persist_excl: assert property (!(persist_shut && persist_if))
        else $error("both persist pulses at once");
    c_answer: cover property (tx_valid);
    c_forced_off: cover property ($fell(output_on) && $past(meas_valid));
    c_persist: cover property (persist_shut);
endmodule
bind olrc_top olrc_asserts olrc_asserts_inst (.*);
`default_nettype wire

// ==== sim/olrc_host.sv ====
// bus-port host and flash image source facing olrc_top
// assumes the bench calls its tasks from one process after reset
`timescale 1ns/1ns
`default_nettype none
module olrc_host
    import olrc_pkg::*;
(
    input wire logic aclk,
    output logic [7:0] rx_char,
    output logic rx_valid,
    output olrc_pkg::olrc_vars_t flash_vars,
    output logic flash_valid
);
    initial begin
        rx_char = 8'h00;
        rx_valid = 1'b0;
        flash_vars = '0;
        flash_valid = 1'b0;
    end
    // ----------------------------------------------------------------
    // host actions
    // ----------------------------------------------------------------
    // image stays valid once loaded
    task automatic load(input olrc_vars_t v);
        @(posedge aclk);
        flash_vars <= v;
        flash_valid <= 1'b1;
    endtask
    // idle line shows the inverse of the last char
    task automatic send(input string s);
        for (int k = 0; k < s.len(); k++) begin
            @(posedge aclk);
            rx_char <= s[k];
            rx_valid <= 1'b1;
        end
        @(posedge aclk);
        rx_valid <= 1'b0;
        rx_char <= ~s[s.len()-1];
    endtask
endmodule
`default_nettype wire

// ==== sim/tb.sv ====
// self-checking bench for olrc_top
// assumes olrc_host as bus-port host and flash image source
`timescale 1ns/1ns
`default_nettype none
module tb
    import olrc_pkg::*;
;
    localparam logic [15:0] VM = 16'hfff0;
    localparam logic [15:0] IM = 16'hffe0;
    logic aclk = 1'b0, aresetn = 1'b0;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00, rx_char, tx_char;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic arvalid = 1'b0, rready = 1'b0, meas_valid = 1'b0;
    logic [31:0] wdata = 32'h0, rdata, rd_data;
    logic [15:0] meas_value = 16'h0, hard_limit = 16'hf000;
    logic awready, wready, bvalid, arready, rvalid, rx_valid, tx_valid;
    logic [1:0] bresp, rresp, resp;
    logic flash_valid, persist_shut, persist_if, factory_erase;
    logic output_on, volt_mode, status_clear;
    logic [2:0] quest_status, dev_error;
    olrc_vars_t flash_vars, persist_vars;
    olrc_lim_t lim_dac, prog_dac;
    int err_count = 0, checked = 0, cyc = 0;
    int n_tx = 0, n_shut = 0, n_if = 0, n_er = 0, n_clr = 0;
    logic [3:0] sels [8] = '{4'h0, 4'h1, 4'h2, 4'h4, 4'h8, 4'h5, 4'ha, 4'hf};

    always #2 aclk = ~aclk;

    olrc_top #(.V_MAX(VM), .I_MAX(IM)) olrc_top_inst (
        .aclk(aclk), .aresetn(aresetn), .s_awaddr(awaddr),
        .s_awvalid(awvalid), .s_awready(awready), .s_wdata(wdata),
        .s_wstrb(4'hf), .s_wvalid(wvalid), .s_wready(wready),
        .s_bresp(bresp), .s_bvalid(bvalid), .s_bready(bready),
        .s_araddr(araddr), .s_arvalid(arvalid), .s_arready(arready),
        .s_rdata(rdata), .s_rresp(rresp), .s_rvalid(rvalid),
        .s_rready(rready), .flash_vars(flash_vars),
        .flash_valid(flash_valid), .persist_vars(persist_vars),
        .persist_shut(persist_shut), .persist_if(persist_if),
        .factory_erase(factory_erase), .meas_value(meas_value),
        .meas_valid(meas_valid), .hard_limit(hard_limit),
        .rx_char(rx_char), .rx_valid(rx_valid), .out_buf_empty(1'b1),
        .lim_dac(lim_dac), .prog_dac(prog_dac), .output_on(output_on),
        .volt_mode(volt_mode), .quest_status(quest_status),
        .dev_error(dev_error), .tx_char(tx_char), .tx_valid(tx_valid),
        .status_clear(status_clear));
    olrc_host olrc_host_inst (.*);

    // ----------------------------------------------------------------
    // tasks
    // ----------------------------------------------------------------
    task automatic results;
        $display("checks %0d mismatches %0d", checked, err_count);
        if (err_count == 0 && checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    // one-cycle pulses are counted, not polled
    always @(posedge aclk) begin
        cyc++;
        n_tx += tx_valid;
        n_shut += persist_shut;
        n_if += persist_if;
        n_er += factory_erase;
        n_clr += status_clear;
        if (cyc == 20000) begin
            err_count++;
            $display("unexpected at %0t: run timed out", $time);
            results;
        end
    end
    task automatic chk(input logic [39:0] got, exp, input string m);
        checked++;
        if (got !== exp) begin
            err_count++;
            $display("unexpected at %0t: %s got %h exp %h", $time, m,
                got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        forever begin
            @(posedge aclk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            if (bvalid) begin
                resp = bresp;
                bready <= 1'b0;
                break;
            end
        end
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        forever begin
            @(posedge aclk);
            if (arvalid && arready) arvalid <= 1'b0;
            if (rvalid) begin
                rd_data = rdata;
                resp = rresp;
                rready <= 1'b0;
                break;
            end
        end
    endtask
    task automatic rc(input logic [7:0] a, input logic [31:0] e);
        rd(a);
        chk(rd_data, e, "register read");
    endtask
    task automatic cmd(input logic [3:0] c);
        wr(A_CMD, {28'h0, c});
        repeat (3) @(posedge aclk);
    endtask
    task automatic ms(input logic [15:0] v);
        @(posedge aclk);
        meas_value <= v;
        meas_valid <= 1'b1;
        @(posedge aclk);
        meas_valid <= 1'b0;
        repeat (2) @(posedge aclk);
    endtask
    // maximum beats the programmed value
    function automatic logic [31:0] exp_lim(input logic [3:0] s);
        logic [15:0] v, i;
        v = s[0] ? VM : (s[2] ? 16'h1234 : 16'h0000);
        i = s[1] ? IM : (s[3] ? 16'h0567 : 16'h0000);
        return {v, i};
    endfunction

    initial begin
        int t;
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        olrc_host_inst.load('{8'h00, 16'h0040, 4'h2, 16'h1234, 16'h0567,
            16'h0000, 3'h0});
        repeat (3) @(posedge aclk);
        rc(A_WINDOW, 32'h40);
        rc(A_OFFSEL, 32'h2);
        wr(A_WINDOW, {16'h0, WINDOW_DEF});
        repeat (3) @(posedge aclk);
        chk(n_shut + n_if, 0, "persist on plain write");
        cmd(C_PERSIST_IF);
        chk({n_if[7:0], n_shut[7:0]}, 16'h0100, "interface persist");
        cmd(C_PERSIST_SHUT);
        chk(n_shut, 1, "shutdown persist");
        chk(persist_vars.window, WINDOW_DEF, "persisted window");
        $display("test persistence done");
        wr(A_OFFLIM, 32'h0567_1234);
        foreach (sels[k]) begin
            wr(A_OFFSEL, {28'h0, sels[k]});
            repeat (3) @(posedge aclk);
            chk(lim_dac, exp_lim(sels[k]), "off limit");
        end
        $display("test off-state limits done");
        wr(A_SETPT, 32'h0010_1000);
        wr(A_ERRCFG, 32'h9);
        wr(A_OFFSEL, 32'h1);
        cmd(C_OUTP_ON);
        ms(16'h1020);
        chk({output_on, quest_status}, 4'b1000, "inside window");
        ms(16'h1021);
        chk({output_on, quest_status, dev_error}, 7'b0001001, "off");
        chk(lim_dac, {VM, 16'h0}, "limits after forced off");
        wr(A_ERRCFG, 32'h4);
        cmd(C_OUTP_ON);
        ms(16'hf100);
        chk({output_on, quest_status, dev_error}, 7'b1101100, "hard");
        $display("test error detection done");
        cmd(C_RST);
        chk({output_on, volt_mode, prog_dac}, {2'b01, 32'h0}, "rst");
        cmd(C_OUTP_ON);
        wr(A_SETPT, 32'h0010_1000);
        repeat (3) @(posedge aclk);
        chk(prog_dac, 32'h1000_0010, "setpoint after on");
        wr(A_SYSOPT, 32'h4);
        cmd(C_RST);
        chk({output_on, prog_dac}, {1'b1, 32'h0}, "rst output on");
        wr(A_SETPT, 32'h0020_2000);
        repeat (3) @(posedge aclk);
        chk(prog_dac, 32'h2000_0020, "direct setpoint");
        t = n_clr;
        cmd(C_DCL);
        chk({output_on, 8'(n_clr - t)}, 9'h101, "status clear");
        wr(A_SYSOPT, 32'h2);
        cmd(C_DCL);
        chk({output_on, volt_mode, prog_dac}, {2'b01, 32'h0}, "dcl");
        $display("test reset and clear done");
        wr(A_SYSOPT, 32'h0);
        t = n_tx;
        olrc_host_inst.send("A\x0d\n");
        repeat (3) @(posedge aclk);
        chk(n_tx - t, 1, "pair answered once");
        olrc_host_inst.send("B\n");
        repeat (3) @(posedge aclk);
        chk(n_tx - t, 2, "line answered");
        wr(A_SYSOPT, 32'h1);
        olrc_host_inst.send("C\n");
        repeat (3) @(posedge aclk);
        chk(n_tx - t, 2, "no answer with option set");
        cmd(C_READ);
        chk(n_tx - t, 3, "empty read answered");
        $display("test line feed answers done");
        wr(A_OFFSEL, 32'hf);
        wr(A_SYSOPT, 32'h7);
        wr(A_WINDOW, 32'h55);
        t = n_er;
        cmd(C_FACTORY);
        chk(n_er - t, 1, "flash erase");
        rc(A_OFFSEL, 32'h0);
        rc(A_SYSOPT, 32'h0);
        rc(A_WINDOW, {16'h0, WINDOW_DEF});
        $display("test factory restore done");
        rd(8'h80);
        chk({resp, rd_data}, {RESP_SLVERR, 32'h0}, "unmapped read");
        wr(8'h84, 32'h1);
        chk(resp, RESP_SLVERR, "unmapped write");
        $display("test unmapped access done");
        results;
    end
endmodule
`default_nettype wire
